// File: logic/glpc_pkg.sv
// package: register map, field positions and timing for the pin configuration block
package glpc_pkg;
    localparam logic [11:0] CFG_OFF = 12'h088;
    localparam logic [11:0] IRQ_STS_OFF = 12'h08C;
    localparam logic [11:0] IRQ_EN_OFF = 12'h090;
    localparam int LED_SEL_LSB = 28;
    localparam int POL_LSB = 24;
    localparam int MEMFN_LSB = 20;
    localparam int BUF_LSB = 16;
    localparam int DIR_LSB = 8;
    localparam int XOUT_LSB = 3;
    localparam int DATA_LSB = 0;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_WMASK = 32'h7777_0718;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam logic [2:0] MEMFN_MEM = 3'h0;
    localparam logic [2:0] MEMFN_XOUT = 3'h1;
    localparam logic [2:0] MEMFN_X3_RXDV = 3'h3;
    localparam logic [2:0] MEMFN_TXEN_X4 = 3'h5;
    localparam logic [2:0] MEMFN_TXEN_RXDV = 3'h6;
    localparam logic [2:0] MEMFN_CLKS = 3'h7;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int ACTIVE_MIN_PS = 40000;
    // input must stay active strictly longer than the minimum, so one cycle beyond it
    localparam int ACTIVE_CYCLES = ACTIVE_MIN_PS / CLK_PERIOD_PS + 1;
    localparam int CNT_W = 4;
endpackage

// File: logic/glpc_pin_irq.sv
// one pin: synchroniser, active-level filter and sticky status bit
`timescale 1ns/10ps
module glpc_pin_irq (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_in,
    input wire logic polarity,
    input wire logic clear,
    output logic level,
    output logic status
);
    logic sync1_r;
    logic sync2_r;
    logic [glpc_pkg::CNT_W-1:0] cnt_r;
    logic active;
    logic hit;

    always_ff @(posedge pclk or negedge presetn) begin // see RQ13
        if (!presetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    assign level = sync2_r;
    assign active = (sync2_r == polarity); // see RQ2
    assign hit = active && (cnt_r == glpc_pkg::CNT_W'(glpc_pkg::ACTIVE_CYCLES - 1));

    // counter saturates so a held level keeps hit high and re-sets the bit every cycle
    always_ff @(posedge pclk or negedge presetn) begin // see RQ4
        if (!presetn) begin
            cnt_r <= '0;
        end else if (!active) begin
            cnt_r <= '0;
        end else if (cnt_r != glpc_pkg::CNT_W'(glpc_pkg::ACTIVE_CYCLES - 1)) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin // see RQ13
        if (!presetn) begin
            status <= 1'b0;
        end else if (hit) begin
            status <= 1'b1;
        end else if (clear) begin
            status <= 1'b0;
        end
    end

    short_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(status) |-> $past(active, 10)) else $error("status set after short pulse"); // see RQ4
    sticky_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        status && !clear |=> status) else $error("status dropped without clear"); // see RQ13
endmodule // glpc_pin_irq

// File: logic/glpc_top.sv
// pin configuration block: apb registers, pin muxing and pin interrupts
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
// Contract
// RQ1: led select bits make pins led outputs
// RQ2: polarity bit picks active pin level
// RQ3: enable bit gates pin interrupt
// RQ4: active level must last over 40 ns
// RQ5: three-bit field picks memory pin functions
// RQ6: host keeps field during memory cycle
// RQ7: host never writes reserved field codes
// RQ8: buffer bit picks push-pull or open-drain
// RQ9: direction bit makes pin output
// RQ10: extra outputs follow bits 3 and 4
// RQ11: data drives outputs, reads return pins
// RQ12: all fields reset to zero
// RQ13: synchronise pins, sticky status until cleared
module glpc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [2:0] pin_in,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe,
    input wire logic [2:0] led_state,
    input wire logic mem_data_out,
    input wire logic mem_data_oe,
    output logic mem_data_in,
    input wire logic mem_clock_out,
    input wire logic tx_en,
    input wire logic tx_clk,
    input wire logic rx_dv,
    input wire logic rx_clk,
    input wire logic serial_mem_data_pin_in,
    output logic serial_mem_data_pin_out,
    output logic serial_mem_data_pin_oe,
    output logic serial_mem_clock_pin,
    output logic mem_pins_owned
);
    logic [31:0] cfg_r;
    logic [2:0] irq_en_r;
    logic [2:0] level;
    logic [2:0] status;
    logic [2:0] clear;
    logic wr;
    logic rd;
    logic mapped;
    logic [2:0] led_output_select;
    logic [2:0] pin_irq_polarity;
    logic [2:0] serial_mem_pin_function;
    logic [2:0] pin_buffer_type;
    logic [2:0] pin_direction;
    logic [1:0] extra_output_value;
    logic [2:0] pin_data_value;
    logic extra_output_3;
    logic extra_output_4;
    logic [2:0] drive_val;
    logic [2:0] drive_en;
    logic md_sync1_r;
    logic md_sync2_r;

    assign led_output_select = cfg_r[glpc_pkg::LED_SEL_LSB +: 3];
    assign pin_irq_polarity = cfg_r[glpc_pkg::POL_LSB +: 3];
    assign serial_mem_pin_function = cfg_r[glpc_pkg::MEMFN_LSB +: 3];
    assign pin_buffer_type = cfg_r[glpc_pkg::BUF_LSB +: 3];
    assign pin_direction = cfg_r[glpc_pkg::DIR_LSB +: 3];
    assign extra_output_value = cfg_r[glpc_pkg::XOUT_LSB +: 2];
    assign pin_data_value = cfg_r[glpc_pkg::DATA_LSB +: 3];

    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign mapped = (paddr == glpc_pkg::CFG_OFF) || (paddr == glpc_pkg::IRQ_STS_OFF)
        || (paddr == glpc_pkg::IRQ_EN_OFF);
    assign pslverr = psel && penable && !mapped;

    // only documented fields are writable; data bits 2:0 hold the drive value
    always_ff @(posedge pclk or negedge presetn) begin // see RQ12
        if (!presetn) begin
            cfg_r <= glpc_pkg::CFG_RESET;
        end else if (wr && paddr == glpc_pkg::CFG_OFF) begin
            cfg_r <= (pwdata & glpc_pkg::CFG_WMASK) | (pwdata & 32'h0000_0007);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_r <= glpc_pkg::IRQ_RESET;
        end else if (wr && paddr == glpc_pkg::IRQ_EN_OFF) begin
            irq_en_r <= pwdata[2:0];
        end
    end

    assign clear = (wr && paddr == glpc_pkg::IRQ_STS_OFF) ? pwdata[2:0] : 3'h0;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pin
            glpc_pin_irq u_pin (
                .pclk(pclk),
                .presetn(presetn),
                .pin_in(pin_in[g]),
                .polarity(pin_irq_polarity[g]),
                .clear(clear[g]),
                .level(level[g]),
                .status(status[g])
            );
        end
    endgenerate

    assign irq = |(status & irq_en_r); // see RQ3

    // read returns live synchronised pin levels in the data bits
    always_ff @(posedge pclk or negedge presetn) begin // see RQ11
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                glpc_pkg::CFG_OFF: prdata <= {cfg_r[31:3], level};
                glpc_pkg::IRQ_STS_OFF: prdata <= {29'h0, status};
                glpc_pkg::IRQ_EN_OFF: prdata <= {29'h0, irq_en_r};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // led mode drives the led state; otherwise direction and data apply
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (led_output_select[i]) begin // see RQ1
                drive_val[i] = led_state[i];
                drive_en[i] = 1'b1;
            end else begin
                drive_val[i] = pin_data_value[i]; // see RQ11
                drive_en[i] = pin_direction[i]; // see RQ9
            end
        end
    end

    // open-drain only pulls low; a high releases the pin
    assign pin_out = drive_val;
    assign pin_oe = drive_en & (pin_buffer_type | ~drive_val); // see RQ8

    assign extra_output_3 = extra_output_value[0]; // see RQ10
    assign extra_output_4 = extra_output_value[1]; // see RQ10

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            md_sync1_r <= 1'b0;
            md_sync2_r <= 1'b0;
        end else begin
            md_sync1_r <= serial_mem_data_pin_in;
            md_sync2_r <= md_sync1_r;
        end
    end
    assign mem_data_in = md_sync2_r;

    // reserved codes fall back to the memory function; host must avoid them
    always_comb begin // see RQ5
        mem_pins_owned = 1'b0;
        serial_mem_data_pin_out = mem_data_out;
        serial_mem_data_pin_oe = mem_data_oe;
        serial_mem_clock_pin = mem_clock_out;
        case (serial_mem_pin_function)
            glpc_pkg::MEMFN_MEM: mem_pins_owned = 1'b1;
            glpc_pkg::MEMFN_XOUT: begin
                serial_mem_data_pin_out = extra_output_3;
                serial_mem_data_pin_oe = 1'b1;
                serial_mem_clock_pin = extra_output_4;
            end
            glpc_pkg::MEMFN_X3_RXDV: begin
                serial_mem_data_pin_out = extra_output_3;
                serial_mem_data_pin_oe = 1'b1;
                serial_mem_clock_pin = rx_dv;
            end
            glpc_pkg::MEMFN_TXEN_X4: begin
                serial_mem_data_pin_out = tx_en;
                serial_mem_data_pin_oe = 1'b1;
                serial_mem_clock_pin = extra_output_4;
            end
            glpc_pkg::MEMFN_TXEN_RXDV: begin
                serial_mem_data_pin_out = tx_en;
                serial_mem_data_pin_oe = 1'b1;
                serial_mem_clock_pin = rx_dv;
            end
            glpc_pkg::MEMFN_CLKS: begin
                serial_mem_data_pin_out = tx_clk;
                serial_mem_data_pin_oe = 1'b1;
                serial_mem_clock_pin = rx_clk;
            end
            default: mem_pins_owned = 1'b1; // see RQ7
        endcase
    end

    sequence cfg_write_s;
        wr && paddr == glpc_pkg::CFG_OFF;
    endsequence

    reset_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> cfg_r == 32'h0) else $error("config not zero after reset"); // see RQ12
    irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> |(status & irq_en_r)) else $error("irq without enabled status"); // see RQ3
    led_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        led_output_select[0] |-> pin_oe[0] == (pin_buffer_type[0] | ~led_state[0])
        && pin_out[0] == led_state[0]) else $error("led pin not driven"); // see RQ1
    dir_input_a: assert property (@(posedge pclk) disable iff (!presetn)
        !led_output_select[1] && !pin_direction[1] |-> !pin_oe[1])
        else $error("input pin driven"); // see RQ9
    open_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pin_buffer_type[2] && pin_out[2] |-> !pin_oe[2])
        else $error("open-drain drove high"); // see RQ8
    xout_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        serial_mem_pin_function == glpc_pkg::MEMFN_XOUT |->
        serial_mem_data_pin_out == cfg_r[3] && serial_mem_clock_pin == cfg_r[4])
        else $error("extra outputs wrong"); // see RQ10
    clks_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        serial_mem_pin_function == glpc_pkg::MEMFN_CLKS |->
        serial_mem_data_pin_out == tx_clk && serial_mem_clock_pin == rx_clk)
        else $error("clock monitor mapping wrong"); // see RQ5
    data_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_write_s |=> cfg_r[2:0] == $past(pwdata[2:0]))
        else $error("data bits not written"); // see RQ11
endmodule // glpc_top

// File: tb/glpc_partner.sv
// board side of the shared pins: pull-ups, external drivers and the serial memory line
`timescale 1ns/10ps
module glpc_partner (
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] ext_val,
    input wire logic [2:0] ext_en,
    output logic [2:0] pin_level,
    input wire logic mem_out,
    input wire logic mem_oe,
    output logic mem_level
);
    // pull-ups hold undriven lines high, so an open-drain release reads back as 1
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_level[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
    assign mem_level = mem_oe ? mem_out : 1'b1;
endmodule // glpc_partner

// File: tb/tb_glpc_top.sv
// testbench: apb host, pin stimulus and inline expected-value checks of the pin configuration block
`timescale 1ns/10ps
module tb_glpc_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r, d;
    logic pready, pslverr, irq, e, mem_data_in, smd_in, smd_out, smd_oe, smc, owned, ec, ed;
    logic [2:0] pin_in, pin_out, pin_oe, eo, lv, c;
    logic [2:0] led_state = 3'h0, ext_val = 3'h0, ext_en = 3'h0;
    logic mem_data_out = 1'b0, mem_data_oe = 1'b0, mem_clock_out = 1'b0;
    logic tx_en = 1'b0, tx_clk = 1'b0, rx_dv = 1'b0, rx_clk = 1'b0;
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
    integer seed = 50;
    int error_cnt = 0;
    int cmp_count = 0;

    always #2 pclk = ~pclk;

    glpc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .led_state(led_state), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe),
        .mem_data_in(mem_data_in), .mem_clock_out(mem_clock_out), .tx_en(tx_en),
        .tx_clk(tx_clk), .rx_dv(rx_dv), .rx_clk(rx_clk), .serial_mem_data_pin_in(smd_in),
        .serial_mem_data_pin_out(smd_out), .serial_mem_data_pin_oe(smd_oe),
        .serial_mem_clock_pin(smc), .mem_pins_owned(owned));
    glpc_partner i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .ext_en(ext_en), .pin_level(pin_in), .mem_out(smd_out), .mem_oe(smd_oe),
        .mem_level(smd_in));

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge: callers then see settled outputs and drive on an edge
        @(posedge pclk);
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // whole run is a few hundred cycles; twenty thousand means a hang
    initial begin
        #80000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // pin levels need two synchroniser edges before a read shows them
        repeat (2) @(posedge pclk);
        apb(1'b0, glpc_pkg::CFG_OFF, 32'h0);
        chk("cfg_reset", 32'h0000_0007, r);
        chk("oe_reset", 32'h0, {29'h0, pin_oe});
        chk("owned_reset", 32'h1, {31'h0, owned});
        apb(1'b1, 12'h0A0, 32'hFFFF_FFFF);
        chk("unmapped_wr_err", 32'h1, {31'h0, e});
        apb(1'b0, 12'h0A0, 32'h0);
        chk("unmapped_rd", 32'h0, r);
        chk("unmapped_rd_err", 32'h1, {31'h0, e});
        $display("test reset_and_map done");
        for (int k = 0; k < 6; k++) begin
            // memory function pinned to 001 so no reserved code is ever written
            d = ($random(seed) & 32'h0707_071F) | 32'h0010_0000;
            apb(1'b1, glpc_pkg::CFG_OFF, d);
            for (int i = 0; i < 3; i++) begin
                eo[i] = d[8+i] & (d[16+i] | ~d[i]);
                lv[i] = d[8+i] ? d[i] : 1'b1;
            end
            chk("pin_oe", {29'h0, eo}, {29'h0, pin_oe});
            chk("pin_out", {29'h0, eo & d[2:0]}, {29'h0, eo & pin_out});
            repeat (3) @(posedge pclk);
            apb(1'b0, glpc_pkg::CFG_OFF, 32'h0);
            chk("cfg_read", (d & glpc_pkg::CFG_WMASK) | {29'h0, lv}, r);
        end
        $display("test pin_drive done");
        led_state <= 3'($random(seed));
        apb(1'b1, glpc_pkg::CFG_OFF, 32'h7007_0000);
        chk("led_oe", 32'h7, {29'h0, pin_oe});
        chk("led_out", {29'h0, led_state}, {29'h0, pin_out});
        $display("test led_select done");
        for (int k = 0; k < 6; k++) begin
            c = codes[k];
            d = $random(seed);
            // bench memory controller runs no cycles, so a field change is safe
            {tx_en, tx_clk, rx_dv, rx_clk, mem_data_out, mem_clock_out, mem_data_oe} <= d[31:25];
            apb(1'b1, glpc_pkg::CFG_OFF, {9'h0, c, 20'h0} | (d & 32'h18));
            ed = (c == 3'h0) ? d[27] : (c == 3'h7) ? d[30] : c[2] ? d[31] : d[3];
            ec = (c == 3'h0) ? d[26] : (c == 3'h7) ? d[28] : c[1] ? d[29] : d[4];
            chk("mem_clock_pin", {31'h0, ec}, {31'h0, smc});
            chk("mem_data_oe", {31'h0, (c == 3'h0) ? d[25] : 1'b1}, {31'h0, smd_oe});
            if (c != 3'h0 || d[25]) begin
                chk("mem_data_pin", {31'h0, ed}, {31'h0, smd_out});
            end
            chk("mem_owned", {31'h0, c == 3'h0}, {31'h0, owned});
            repeat (2) @(posedge pclk);
            chk("mem_data_in", {31'h0, (c == 3'h0 && !d[25]) ? 1'b1 : ed}, {31'h0, mem_data_in});
        end
        $display("test mem_function done");
        apb(1'b1, glpc_pkg::CFG_OFF, 32'h0);
        apb(1'b1, glpc_pkg::IRQ_STS_OFF, 32'h7);
        apb(1'b1, glpc_pkg::IRQ_EN_OFF, 32'h2);
        ext_val <= 3'h0;
        ext_en <= 3'h2;
        repeat (10) @(posedge pclk);
        ext_en <= 3'h0;
        repeat (20) @(posedge pclk);
        apb(1'b0, glpc_pkg::IRQ_STS_OFF, 32'h0);
        chk("short_pulse", 32'h0, r & 32'h7);
        ext_en <= 3'h2;
        repeat (20) @(posedge pclk);
        ext_en <= 3'h0;
        apb(1'b0, glpc_pkg::IRQ_STS_OFF, 32'h0);
        chk("low_active", 32'h2, r & 32'h7);
        chk("irq_on", 32'h1, {31'h0, irq});
        apb(1'b1, glpc_pkg::IRQ_EN_OFF, 32'h0);
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b0, glpc_pkg::IRQ_STS_OFF, 32'h0);
        chk("sticky", 32'h2, r & 32'h7);
        apb(1'b1, glpc_pkg::IRQ_STS_OFF, 32'h2);
        apb(1'b0, glpc_pkg::IRQ_STS_OFF, 32'h0);
        chk("w1c", 32'h0, r & 32'h7);
        apb(1'b1, glpc_pkg::CFG_OFF, 32'h0400_0000);
        repeat (20) @(posedge pclk);
        apb(1'b0, glpc_pkg::IRQ_STS_OFF, 32'h0);
        chk("high_active", 32'h4, r & 32'h7);
        chk("irq_gated", 32'h0, {31'h0, irq});
        // level still active, so the set beats the write-one clear
        apb(1'b1, glpc_pkg::IRQ_STS_OFF, 32'h4);
        apb(1'b0, glpc_pkg::IRQ_STS_OFF, 32'h0);
        chk("set_wins", 32'h4, r & 32'h7);
        $display("test pin_interrupt done");
        print_verdict();
    end
endmodule // tb_glpc_top
